// [core/i2c_target_defs.vh]
// Constants for the serial register access target
// Assumes inclusion by the core design files only
`ifndef I2C_TARGET_DEFS_VH
`define I2C_TARGET_DEFS_VH
`define ADDR_FIXED_BITS 6'h06
`define MASTER_CODE_TOP 5'h01
`define LOW_GRP_END 8'h03
`define LOW_GRP_JUMP 8'h10
`define LOW_GRP_LAST 8'h18
`define LOW_GRP_FIRST 8'h00
`define CTL_GRP_FIRST 8'h30
`define CTL_GRP_LAST 8'h32
`define ROM_GRP_FIRST 8'h60
`define ROM_GRP_LAST 8'h62
`define ADDR_RESET 8'h00
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define BYTE_W 8
`define CLK_PERIOD_NS 10
`define SCL_MAX_HS_KHZ 2500
`define SCL_HS_PERIOD_NS 400
// Fewest clock cycles in one high-speed serial clock period
`define SCL_HS_CYCLES (`SCL_HS_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// [core/sync_two_flop.v]
// Two flip-flop synchroniser for one level from outside the clock domain
// Assumes the receiving clock and an asynchronous active-low reset
`default_nettype none
module sync_two_flop #(
    parameter RESET_VALUE = 1'b1
) (
    input wire clock,
    input wire rst_b,
    input wire asyncIn,
    output reg syncOut
);
    reg stage1;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule
`default_nettype wire

// [core/byte_fifo.v]
// Small first-in first-out buffer in flip-flops, valid/ready on both sides
// Assumes one clock; writer and reader share it
`default_nettype none
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clock,
    input wire rst_b,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] count;
    wire doWrite;
    wire doRead;

    assign inReady = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData = mem[rdPtr];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    always @(posedge clock) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doRead) begin
                rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doWrite && !doRead) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (doRead && !doWrite) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// [core/i2c_register_target.v]
// Serial two-wire target giving a bus master byte access to registers
// Assumes a 100 MHz clock; bus pins arrive asynchronously; the register
// store sits outside and answers readData combinationally from regAddr
`default_nettype none
`include "i2c_target_defs.vh"
module i2c_register_target (
    input wire clock,
    input wire rst_b,
    input wire serialClockIn,
    input wire serialDataIn,
    output reg serialDataOut,
    output reg serialDataOe,
    input wire address_select_pin,
    output reg [7:0] regAddr,
    input wire [7:0] readData,
    input wire regWritable,
    output reg [7:0] writeData,
    output reg writeStrobe,
    input wire writeReady,
    output reg highSpeedMode,
    output reg busBusy
);
    // -----------------------------------------------------------------
    // Pin sampling
    // -----------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_RECV = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_SEND = 3'h3;
    localparam ST_MACK = 3'h4;
    localparam ST_IGNORE = 3'h5;

    wire sclSync;
    wire sdaSync;
    reg sclPrev;
    reg sdaPrev;
    wire strapSync;

    sync_two_flop #(.RESET_VALUE(1'b1)) uSyncScl (
        .clock(clock),
        .rst_b(rst_b),
        .asyncIn(serialClockIn),
        .syncOut(sclSync)
    );
    sync_two_flop #(.RESET_VALUE(1'b1)) uSyncSda (
        .clock(clock),
        .rst_b(rst_b),
        .asyncIn(serialDataIn),
        .syncOut(sdaSync)
    );
    sync_two_flop #(.RESET_VALUE(1'b0)) uSyncStrap (
        .clock(clock),
        .rst_b(rst_b),
        .asyncIn(address_select_pin),
        .syncOut(strapSync)
    );

    wire sclRise = sclSync && !sclPrev;
    wire sclFall = !sclSync && sclPrev;
    wire startSeen = sclSync && sclPrev && sdaPrev && !sdaSync;
    wire stopSeen = sclSync && sclPrev && !sdaPrev && sdaSync;

    // -----------------------------------------------------------------
    // Write data buffer
    // -----------------------------------------------------------------
    // Each entry: register address above data byte
    reg fifoInValid;
    reg [15:0] fifoInData;
    wire fifoInReady;
    wire fifoOutValid;
    wire [15:0] fifoOutData;
    wire popNow;

    byte_fifo #(
        .WIDTH(2 * `BYTE_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) uWriteFifo (
        .clock(clock),
        .rst_b(rst_b),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(popNow),
        .outData(fifoOutData)
    );

    // -----------------------------------------------------------------
    // Transfer state
    // -----------------------------------------------------------------
    reg [2:0] state;
    reg [3:0] bitCount;
    reg [7:0] shiftReg;
    reg [1:0] byteIndex;
    reg readDir;
    reg ackThis;
    reg hsPending;
    reg [7:0] addrCounter;
    reg headShown;

    // Next register address within its group
    function [7:0] next_addr;
        input [7:0] cur;
        begin
            if (cur == `LOW_GRP_END) begin
                next_addr = `LOW_GRP_JUMP;
            end else if (cur == `LOW_GRP_LAST) begin
                next_addr = `LOW_GRP_FIRST;
            end else if (cur == `CTL_GRP_LAST) begin
                next_addr = `CTL_GRP_FIRST;
            end else if (cur == `ROM_GRP_LAST) begin
                next_addr = `ROM_GRP_FIRST;
            end else begin
                next_addr = cur + 8'h01;
            end
        end
    endfunction

    wire [6:0] ownAddr = {`ADDR_FIXED_BITS, strapSync};

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
            state <= ST_IDLE;
            bitCount <= 4'h0;
            shiftReg <= 8'h00;
            byteIndex <= 2'd0;
            readDir <= 1'b0;
            ackThis <= 1'b0;
            hsPending <= 1'b0;
            highSpeedMode <= 1'b0;
            busBusy <= 1'b0;
            addrCounter <= `ADDR_RESET;
            serialDataOut <= 1'b1;
            serialDataOe <= 1'b0;
            fifoInValid <= 1'b0;
            fifoInData <= 16'h0000;
        end else begin
            sclPrev <= sclSync;
            sdaPrev <= sdaSync;
            fifoInValid <= 1'b0;
            if (startSeen) begin
                busBusy <= 1'b1;
                state <= ST_RECV;
                bitCount <= 4'h0;
                byteIndex <= 2'd0;
                serialDataOe <= 1'b0;
                if (hsPending) begin
                    highSpeedMode <= 1'b1;
                    hsPending <= 1'b0;
                end
            end else if (stopSeen) begin
                busBusy <= 1'b0;
                state <= ST_IDLE;
                serialDataOe <= 1'b0;
                highSpeedMode <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        serialDataOe <= 1'b0;
                    end
                    ST_IGNORE: begin
                        serialDataOe <= 1'b0;
                    end
                    ST_RECV: begin
                        if (sclRise) begin
                            shiftReg <= {shiftReg[6:0], sdaSync};
                            bitCount <= bitCount + 4'h1;
                        end else if (sclFall && bitCount == 4'h8) begin
                            // Eighth bit done; decide the ninth pulse
                            state <= ST_ACK;
                            ackThis <= 1'b1;
                            if (byteIndex == 2'd0) begin
                                readDir <= shiftReg[0];
                                if (shiftReg[7:1] != ownAddr) begin
                                    ackThis <= 1'b0;
                                    if (shiftReg[7:3] == `MASTER_CODE_TOP &&
                                            !highSpeedMode) begin
                                        hsPending <= 1'b1;
                                    end
                                end
                            end else if (byteIndex == 2'd1) begin
                                addrCounter <= shiftReg;
                            end else if (fifoInReady) begin
                                fifoInData <= {addrCounter, shiftReg};
                                fifoInValid <= 1'b1;
                                addrCounter <= next_addr(addrCounter);
                            end else begin
                                ackThis <= 1'b0;
                            end
                            if (ackThis || byteIndex != 2'd0 ||
                                    shiftReg[7:1] == ownAddr) begin
                                serialDataOut <= 1'b0;
                            end
                            serialDataOe <= (byteIndex != 2'd0) ?
                                fifoInReady || byteIndex == 2'd1 :
                                shiftReg[7:1] == ownAddr;
                        end
                    end
                    ST_ACK: begin
                        if (sclFall) begin
                            // Ninth pulse over; data line changes on low
                            serialDataOe <= 1'b0;
                            if (!ackThis) begin
                                state <= ST_IGNORE;
                            end else if (byteIndex == 2'd0 && readDir) begin
                                state <= ST_SEND;
                                shiftReg <= {readData[6:0], 1'b0};
                                serialDataOut <= readData[7];
                                serialDataOe <= !readData[7];
                                addrCounter <= next_addr(addrCounter);
                                bitCount <= 4'h1;
                            end else begin
                                state <= ST_RECV;
                                bitCount <= 4'h0;
                                if (byteIndex != 2'd2) begin
                                    byteIndex <= byteIndex + 2'd1;
                                end
                            end
                        end
                    end
                    ST_SEND: begin
                        if (sclFall) begin
                            if (bitCount == 4'h8) begin
                                serialDataOe <= 1'b0;
                                state <= ST_MACK;
                            end else begin
                                serialDataOut <= shiftReg[7];
                                serialDataOe <= !shiftReg[7];
                                shiftReg <= {shiftReg[6:0], 1'b0};
                                bitCount <= bitCount + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (sclRise) begin
                            if (sdaSync) begin
                                state <= ST_IGNORE;
                            end else begin
                                ackThis <= 1'b1;
                            end
                        end else if (sclFall) begin
                            state <= ST_SEND;
                            shiftReg <= {readData[6:0], 1'b0};
                            serialDataOut <= readData[7];
                            serialDataOe <= !readData[7];
                            addrCounter <= next_addr(addrCounter);
                            bitCount <= 4'h1;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Register side outputs
    // -----------------------------------------------------------------
    // Head address shown a cycle ahead so writability is settled at pop
    assign popNow = fifoOutValid && writeReady && headShown;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            regAddr <= `ADDR_RESET;
            headShown <= 1'b0;
            writeData <= 8'h00;
            writeStrobe <= 1'b0;
        end else begin
            writeStrobe <= 1'b0;
            if (popNow) begin
                // Address held through the strobe cycle
                headShown <= 1'b0;
                writeData <= fifoOutData[7:0];
                writeStrobe <= regWritable;
            end else if (!headShown) begin
                regAddr <= fifoOutValid ? fifoOutData[15:8] : addrCounter;
                headShown <= fifoOutValid;
            end
        end
    end
endmodule
`default_nettype wire

// [bench/i2c_register_target_chk.sv]
// Port checker for the serial register target
// Assumes binding onto i2c_register_target; pins seen raw
`default_nettype none
module i2c_register_target_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic serialClockIn,
    input wire logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire logic writeStrobe,
    input wire logic writeReady,
    input wire logic highSpeedMode,
    input wire logic busBusy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_oeMoves;
        $changed(serialDataOe) |-> !serialClockIn;
    endproperty
    a_oeMoves: assert property (p_oeMoves)
        else $error("drive moved while clock high");
    property p_driveInFrame;
        serialDataOe |-> busBusy;
    endproperty
    a_driveInFrame: assert property (p_driveInFrame)
        else $error("drive outside a frame");
    property p_startBusy;
        $fell(serialDataIn) && serialClockIn |-> ##[1:6] busBusy;
    endproperty
    a_startBusy: assert property (p_startBusy)
        else $error("start not seen");
    property p_stopIdle;
        $rose(serialDataIn) && serialClockIn |-> ##[1:6] !busBusy;
    endproperty
    a_stopIdle: assert property (p_stopIdle)
        else $error("stop not seen");
    property p_stopLeavesFast;
        $rose(serialDataIn) && serialClockIn |-> ##[1:8] !highSpeedMode;
    endproperty
    a_stopLeavesFast: assert property (p_stopLeavesFast)
        else $error("fast mode stays after stop");
    property p_strobeReady;
        writeStrobe |-> writeReady;
    endproperty
    a_strobeReady: assert property (p_strobeReady)
        else $error("write issued without ready");
    property p_driveStands;
        $rose(serialDataOe) |=> serialDataOe [*8];
    endproperty
    a_driveStands: assert property (p_driveStands)
        else $error("low drive too short");
    property p_fastInFrame;
        $rose(highSpeedMode) |-> busBusy;
    endproperty
    a_fastInFrame: assert property (p_fastInFrame)
        else $error("fast mode entered outside frame");
    property p_driveLow;
        serialDataOe |-> !serialDataOut;
    endproperty
    a_driveLow: assert property (p_driveLow)
        else $error("drive enabled with a high value");
endmodule
bind i2c_register_target i2c_register_target_chk u_chk (
    .clock(clock), .rst_b(rst_b), .serialClockIn(serialClockIn),
    .serialDataIn(serialDataIn), .serialDataOe(serialDataOe),
    .serialDataOut(serialDataOut),
    .writeStrobe(writeStrobe), .writeReady(writeReady),
    .highSpeedMode(highSpeedMode), .busBusy(busBusy));
`default_nettype wire

// [bench/i2c_master_model.sv]
// Behavioural bus master with a 125 ns serial clock
// Assumes a pulled-up data line resolved by the bench
`default_nettype none
module i2c_master_model (
    output logic sclOut,
    output logic sdaLow,
    input wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 10ps;
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic bitx(input logic b, output logic s);
        sclOut = 1'b0;
        #31.25 sdaLow = !b;
        #31.25 sclOut = 1'b1;
        #31.25 s = sdaLine;
        #31.25;
    endtask
    task automatic startBit;
        sdaLow = 1'b1;
        #62.5;
    endtask
    task automatic restartBit;
        logic s;
        bitx(1'b1, s);
        startBit();
    endtask
    task automatic stopBit;
        sclOut = 1'b0;
        #31.25 sdaLow = 1'b1;
        #31.25 sclOut = 1'b1;
        #31.25 sdaLow = 1'b0;
        #62.5;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic [7:0] ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, s);
        ack = {7'h00, !s};
    endtask
    task automatic rbyte(input logic mAck, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(!mAck, s);
    endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the serial register target
// Assumes the master model on the bus and a behavioural store here
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 0, rst_b = 0, strap = 0, writeReady = 1;
    logic sdaOe, sdaOut, strobe, hsMode, busy, writable;
    logic [7:0] regAddr, readData, wrData;
    logic [7:0] mem [0:255];
    logic [7:0] shadow [0:255];
    logic [7:0] wrLog [$];
    int failures = 0, tests_run = 0, cycles = 0;
    wire logic sclLine, mstLow;
    wire logic sdaLine = !(mstLow || sdaOe);
    wire logic [6:0] dev = {6'h06, strap};
    always #5 clock = ~clock;
    i2c_master_model u_mst (.sclOut(sclLine), .sdaLow(mstLow),
        .sdaLine(sdaLine));
    i2c_register_target u_dut (.clock(clock), .rst_b(rst_b),
        .serialClockIn(sclLine), .serialDataIn(sdaLine),
        .serialDataOut(sdaOut), .serialDataOe(sdaOe),
        .address_select_pin(strap), .regAddr(regAddr),
        .readData(readData), .regWritable(writable), .writeData(wrData),
        .writeStrobe(strobe), .writeReady(writeReady),
        .highSpeedMode(hsMode), .busBusy(busy));
    function automatic logic isRw(input logic [7:0] a);
        return a >= 8'h30 && a <= 8'h32;
    endfunction
    function automatic logic [7:0] nextAddr(input logic [7:0] a);
        case (a)
            8'h03: return 8'h10;
            8'h18: return 8'h00;
            8'h32: return 8'h30;
            8'h62: return 8'h60;
            default: return a + 8'h01;
        endcase
    endfunction
    assign readData = mem[regAddr];
    assign writable = isRw(regAddr);
    always @(posedge clock) begin
        if (strobe) begin
            wrLog.push_back(wrData);
            mem[regAddr] <= wrData;
        end
    end
    task automatic close_out;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_reset(input logic s);
        @(negedge clock);
        rst_b = 1'b0;
        strap = s;
        repeat (3) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
    endtask
    task automatic setAddr(input logic [7:0] ra);
        logic [7:0] a;
        u_mst.startBit();
        u_mst.wbyte({dev, 1'b0}, a);
        chk("address ack", a, 8'h01);
        u_mst.wbyte(ra, a);
        chk("register ack", a, 8'h01);
    endtask
    task automatic readFrom(input logic [7:0] ra, input int n,
        output logic [7:0] e);
        logic [7:0] a, d;
        setAddr(ra);
        u_mst.restartBit();
        u_mst.wbyte({dev, 1'b1}, a);
        chk("read ack", a, 8'h01);
        e = ra;
        for (int i = 0; i < n; i++) begin
            u_mst.rbyte(i < n - 1, d);
            chk("read data", d, shadow[e]);
            e = nextAddr(e);
        end
        u_mst.stopBit();
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] a, d, e, starts [4];
        logic [7:0] expQ [$];
        int n;
        starts = '{8'h02, 8'h16, 8'h30, 8'h61};
        void'($urandom(32'h2362));
        for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
        for (int i = 0; i < 256; i++) shadow[i] = mem[i];
        for (int s = 1; s >= 0; s--) begin
            do_reset(s[0]);
            for (int k = 0; k < 2; k++) begin
                u_mst.startBit();
                u_mst.wbyte({6'h06, k[0], 1'b0}, a);
                chk("match ack", a, {7'h00, k == s});
                if (k != s) begin
                    u_mst.wbyte(8'h00, a);
                    chk("ignored byte", a, 8'h00);
                end
                u_mst.stopBit();
            end
        end
        u_mst.startBit();
        u_mst.wbyte({5'h01, 3'($urandom)}, a);
        chk("master code nack", a, 8'h00);
        u_mst.restartBit();
        u_mst.wbyte({dev, 1'b0}, a);
        chk("fast address ack", a, 8'h01);
        chk("fast mode", {7'h00, hsMode}, 8'h01);
        u_mst.stopBit();
        repeat (10) @(negedge clock);
        chk("fast mode left", {7'h00, hsMode}, 8'h00);
        wrLog.delete();
        setAddr(8'h31);
        e = 8'h31;
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            u_mst.wbyte(d, a);
            chk("data ack", a, 8'h01);
            expQ.push_back(d);
            shadow[e] = d;
            e = nextAddr(e);
        end
        u_mst.stopBit();
        setAddr(8'h10);
        u_mst.wbyte(~shadow[8'h10], a);
        chk("read-only ack", a, 8'h01);
        u_mst.stopBit();
        repeat (20) @(negedge clock);
        chk("write count", 8'(wrLog.size()), 8'h04);
        foreach (expQ[i]) chk("write data", wrLog[i], expQ[i]);
        foreach (starts[i]) readFrom(starts[i], 5, e);
        u_mst.startBit();
        u_mst.wbyte({dev, 1'b1}, a);
        u_mst.rbyte(1'b0, d);
        chk("current read", d, shadow[e]);
        u_mst.stopBit();
        @(negedge clock);
        writeReady = 1'b0;
        wrLog.delete();
        setAddr(8'h30);
        n = 0;
        a = 8'h01;
        while (a == 8'h01 && n < 12) begin
            u_mst.wbyte(8'($urandom), a);
            if (a == 8'h01) n++;
        end
        u_mst.stopBit();
        chk("fifo holds eight", 8'(n), 8'h08);
        chk("fifo refuses", {7'h00, n < 12}, 8'h01);
        @(negedge clock);
        writeReady = 1'b1;
        repeat (40) @(negedge clock);
        chk("drained count", 8'(wrLog.size()), 8'(n));
        close_out();
    end
endmodule
`default_nettype wire
